// ---- core/interrupt_control_unit.v ----
/*
 * Interrupt control unit: 31 level maskable requests, one external
 * non-maskable input, vector register and Wishbone classic slave.
 * Assumes irq_i and nmi_n_i are asynchronous to clk_i; synchronous reset.
 */
// Our own choices: the register addresses and the Wishbone register port.
`include "icu_defines.vh"

module interrupt_control_unit #(
	parameter NREQ = 32
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:2] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg wb_err_o,
	input wire [NREQ-1:1] irq_i,
	input wire nmi_n_i,
	input wire inta_i,
	output reg irq_o,
	output reg nmi_o,
	output reg [7:0] vector_o
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [NREQ-1:1] irq_meta_q;
	reg [NREQ-1:1] irq_sync_q;
	reg nmi_meta_q;
	reg nmi_sync_q;
	reg nmi_last_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_meta_q <= {(NREQ-1){1'b0}};
			irq_sync_q <= {(NREQ-1){1'b0}};
			nmi_meta_q <= 1'b1;
			nmi_sync_q <= 1'b1;
			nmi_last_q <= 1'b1;
		end else begin
			irq_meta_q <= irq_i;
			irq_sync_q <= irq_meta_q;
			nmi_meta_q <= nmi_n_i;
			nmi_sync_q <= nmi_meta_q;
			nmi_last_q <= nmi_sync_q;
		end
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [15:0] request_enable_low_q;
	reg [15:0] request_enable_high_q;
	reg external_request_flag_q;
	reg trap_enable_q;
	reg trap_enable_lock_q;
	reg trap_test_bit_q;

	wire [NREQ-1:0] raw_level;
	wire [NREQ-1:0] enables;
	wire [NREQ-1:0] pending;
	wire [4:0] win_idx;
	wire any_pending;
	wire nmi_fall;
	wire trap_armed;
	wire acc;
	wire wr;
	wire rd;
	wire mapped;
	reg [31:0] rd_data;

	assign raw_level = {irq_sync_q, 1'b0};
	assign enables = {request_enable_high_q, request_enable_low_q};
	assign pending = raw_level & enables & {{(NREQ-1){1'b1}}, 1'b0};

	assign trap_armed = trap_enable_lock_q | trap_enable_q;
	assign nmi_fall = nmi_last_q & ~nmi_sync_q;

	assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr = acc & wb_we_i & mapped;
	assign rd = acc & ~wb_we_i & mapped;

	icu_prio_encoder #(
		.N(NREQ),
		.W(5)
	) u_prio (
		.req_i(pending),
		.idx_o(win_idx),
		.any_o(any_pending)
	);

	// ----------------------------------------
	// Address decode and read mux
	// ----------------------------------------
	assign mapped = (wb_adr_i == `ICU_IDX_VECTOR) | (wb_adr_i == `ICU_IDX_NMI_STAT) |
		(wb_adr_i == `ICU_IDX_TRAP_CTRL) | (wb_adr_i == `ICU_IDX_LEVEL_LOW) |
		(wb_adr_i == `ICU_IDX_LEVEL_HIGH) | (wb_adr_i == `ICU_IDX_ENA_LOW) |
		(wb_adr_i == `ICU_IDX_ENA_HIGH);

	always @* begin
		rd_data = 32'h00000000;
		case (wb_adr_i)
			`ICU_IDX_VECTOR: begin
				rd_data[7:0] = vector_o;
			end
			`ICU_IDX_NMI_STAT: begin
				rd_data[`ICU_EXT_BIT] = external_request_flag_q;
			end
			`ICU_IDX_TRAP_CTRL: begin
				rd_data[`ICU_EN_BIT] = trap_enable_q;
				rd_data[`ICU_PIN_BIT] = ~nmi_sync_q;
				rd_data[`ICU_LCK_BIT] = trap_enable_lock_q;
				rd_data[`ICU_TST_BIT] = trap_test_bit_q;
			end
			`ICU_IDX_LEVEL_LOW: begin
				rd_data[15:0] = raw_level[15:0];
			end
			`ICU_IDX_LEVEL_HIGH: begin
				rd_data[15:0] = raw_level[31:16];
			end
			`ICU_IDX_ENA_LOW: begin
				rd_data[15:0] = request_enable_low_q;
			end
			`ICU_IDX_ENA_HIGH: begin
				rd_data[15:0] = request_enable_high_q;
			end
			default: begin
				rd_data = 32'h00000000;
			end
		endcase
	end

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	// One-cycle registered answer; unmapped addresses get err
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= acc & mapped;
			wb_err_o <= acc & ~mapped;
			wb_dat_o <= (acc & ~wb_we_i & mapped) ? rd_data : 32'h00000000;
		end
	end

	// ----------------------------------------
	// Enable registers
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			request_enable_low_q <= `ICU_ENA_RESET;
			request_enable_high_q <= `ICU_ENA_RESET;
		end else if (wr) begin
			if (wb_adr_i == `ICU_IDX_ENA_LOW) begin
				if (wb_sel_i[0]) begin
					request_enable_low_q[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					request_enable_low_q[15:8] <= wb_dat_i[15:8];
				end
			end
			if (wb_adr_i == `ICU_IDX_ENA_HIGH) begin
				if (wb_sel_i[0]) begin
					request_enable_high_q[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					request_enable_high_q[15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

	// ----------------------------------------
	// Non-maskable trap control
	// ----------------------------------------
	wire ctrl_wr;
	wire stat_rd;
	wire nmi_take;

	assign ctrl_wr = wr & (wb_adr_i == `ICU_IDX_TRAP_CTRL) & wb_sel_i[0];
	assign stat_rd = rd & (wb_adr_i == `ICU_IDX_NMI_STAT);
	assign nmi_take = nmi_fall & trap_armed;

	always @(posedge clk_i) begin
		if (rst_i) begin
			trap_enable_q <= 1'b0;
			trap_enable_lock_q <= 1'b0;
			trap_test_bit_q <= 1'b0;
			external_request_flag_q <= 1'b0;
		end else begin
			if (nmi_take) begin
				external_request_flag_q <= 1'b1;
			end else if (stat_rd) begin
				external_request_flag_q <= 1'b0;
			end
			if (nmi_take) begin
				trap_enable_q <= 1'b0;
			end else if (ctrl_wr) begin
				if (!wb_dat_i[`ICU_EN_BIT]) begin
					trap_enable_q <= 1'b0;
				end else if (!external_request_flag_q) begin
					trap_enable_q <= 1'b1;
				end
			end
			if (ctrl_wr && wb_dat_i[`ICU_LCK_BIT]) begin
				trap_enable_lock_q <= 1'b1;
			end
			if (ctrl_wr) begin
				trap_test_bit_q <= wb_dat_i[`ICU_TST_BIT];
			end
		end
	end

	// ----------------------------------------
	// Outputs to the core
	// ----------------------------------------
	// Vector frozen while inta_i is high so the acknowledge read sees one value
	always @(posedge clk_i) begin
		if (rst_i) begin
			vector_o <= {2'b00, `ICU_VEC_BASE};
			irq_o <= 1'b0;
			nmi_o <= 1'b0;
		end else begin
			if (!inta_i) begin
				vector_o <= {2'b00, `ICU_VEC_BASE + {1'b0, win_idx}};
			end
			irq_o <= any_pending;
			nmi_o <= nmi_take;
		end
	end
endmodule

// ---- core/icu_defines.vh ----
/*
 * Register offsets, field positions and reset values of the interrupt control unit.
 * Assumes a Wishbone classic slave with 32-bit data, one register per aligned word.
 */
`ifndef ICU_DEFINES_VH
`define ICU_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define ICU_IDX_VECTOR     4'h0
`define ICU_IDX_NMI_STAT   4'h1
`define ICU_IDX_TRAP_CTRL  4'h2
`define ICU_IDX_LEVEL_LOW  4'h5
`define ICU_IDX_LEVEL_HIGH 4'h6
`define ICU_IDX_ENA_LOW    4'h7
`define ICU_IDX_ENA_HIGH   4'h8

// ----------------------------------------
// Fields
// ----------------------------------------
`define ICU_EXT_BIT        0
`define ICU_EN_BIT         0
`define ICU_PIN_BIT        1
`define ICU_LCK_BIT        2
`define ICU_TST_BIT        3
`define ICU_VEC_BASE       6'h10
`define ICU_ENA_RESET      16'hFFFF

`endif

// ---- core/icu_prio_encoder.v ----
/*
 * Fixed-priority encoder: highest set bit of the pending vector wins.
 * Assumes bit 0 is already forced low by the caller when unused.
 */
module icu_prio_encoder #(
	parameter N = 32,
	parameter W = 5
) (
	input wire [N-1:0] req_i,
	output reg [W-1:0] idx_o,
	output wire any_o
);
	integer k;

	assign any_o = |req_i;

	// Scan upward so higher numbers overwrite lower ones
	always @* begin
		idx_o = {W{1'b0}};
		for (k = 0; k < N; k = k + 1) begin
			if (req_i[k]) begin
				idx_o = k[W-1:0];
			end
		end
	end
endmodule

// ---- dv/icu_monitor.sv ----
/*
 * Port checker for the interrupt control unit, bound to its top module.
 * Assumes synchronous active-high reset and the designer's register indices.
 */
`include "icu_defines.vh"
module icu_monitor #(
	parameter NREQ = 32
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:2] wb_adr_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire wb_err_o,
	input wire [NREQ-1:1] irq_i,
	input wire nmi_n_i,
	input wire inta_i,
	input wire irq_o,
	input wire nmi_o,
	input wire [7:0] vector_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	bus_answer_a: assert property (take |=> wb_ack_o ^ wb_err_o) else $error("bus request unanswered");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	vec_range_a: assert property (vector_o[7:6] == 2'b00 && vector_o[5:4] != 2'b00)
		else $error("vector outside range");
	vec_freeze_a: assert property (inta_i [*2] |-> $stable(vector_o)) else $error("vector moved in ack");
	irq_idle_a: assert property ((irq_i == 0) [*4] |-> !irq_o) else $error("request with nothing pending");
	nmi_cause_a: assert property (nmi_o |-> !($past(nmi_n_i, 2) & $past(nmi_n_i, 3) & $past(nmi_n_i, 4)))
		else $error("trap without pin fall");
	nmi_pulse_a: assert property (nmi_o |=> !nmi_o) else $error("trap pulse too long");
	lvl_bit0_a: assert property ($past(take & !wb_we_i & wb_adr_i == `ICU_IDX_LEVEL_LOW) & wb_ack_o
		|-> !wb_dat_o[0]) else $error("level bit 0 set");
	vec_read_a: assert property ($past(take & !wb_we_i & wb_adr_i == `ICU_IDX_VECTOR) & wb_ack_o
		|-> wb_dat_o[31:6] == 26'h0) else $error("vector upper bits set");
	cover property (nmi_o);
	cover property (inta_i ##1 inta_i);
	cover property (wb_err_o);
endmodule

bind interrupt_control_unit icu_monitor #(.NREQ(NREQ)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq_i(irq_i), .nmi_n_i(nmi_n_i), .inta_i(inta_i),
	.irq_o(irq_o), .nmi_o(nmi_o), .vector_o(vector_o));

// ---- dv/cpu_core_model.sv ----
/*
 * Processor core model running acknowledge cycles on the request line.
 * Assumes the same clock as the block; hold_i stretches each cycle.
 */
module cpu_core_model (
	input wire clk_i,
	input wire rst_i,
	input wire irq_i,
	input wire [7:0] vector_i,
	input wire [3:0] hold_i,
	output logic inta_o,
	output logic [7:0] vec_o,
	output logic [7:0] taken_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_q;
	always @(posedge clk_i) begin
		if (rst_i) begin
			inta_o <= 1'b0;
			cnt_q <= 4'h0;
			vec_o <= 8'h00;
			taken_o <= 8'h00;
		end else if (!inta_o) begin
			inta_o <= irq_i;
			cnt_q <= hold_i;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end else begin
			// Byte taken only at the close, so a slow core sees a frozen value
			vec_o <= vector_i;
			taken_o <= taken_o + 8'h01;
			inta_o <= 1'b0;
		end
	end
endmodule

// ---- dv/testbench.sv ----
/*
 * Self-checking bench for the interrupt control unit.
 * Assumes a Wishbone classic slave answering in one cycle.
 */
`include "icu_defines.vh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, rst_i, cyc, we, ack, err, nmi, irq_o, nmi_o, inta, last_err;
	logic [3:0] adr, hold;
	logic [31:0] dat, rdat, q;
	logic [31:1] irq;
	logic [7:0] vec, cvec, taken;
	int num_errors, n_checks, cycles;
	interrupt_control_unit DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
		.irq_i(irq), .nmi_n_i(nmi), .inta_i(inta), .irq_o(irq_o), .nmi_o(nmi_o), .vector_o(vec));
	cpu_core_model cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o), .vector_i(vec), .hold_i(hold),
		.inta_o(inta), .vec_o(cvec), .taken_o(taken));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (!(ack | err) && n < 20);
		if (n >= 20) begin
			num_errors++;
			$display("CHECK FAILED at %0t: bus wait %h expected %h", $time, n, 0);
		end
		q = rdat;
		last_err = err;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic core_vec(input logic [7:0] e);
		logic [7:0] t;
		t = taken;
		// Third acknowledge: the first two may still carry a vector frozen before the new level arrived
		for (int i = 0; i < 120 && taken != t + 8'h03; i++) @(posedge clk_i);
		chk(taken, t + 8'h03);
		chk(cvec, e);
	endtask
	task automatic pin_fall();
		int i;
		nmi <= 1'b0;
		for (i = 0; i < 8 && nmi_o !== 1'b1; i++) @(posedge clk_i);
		chk(i < 8, 1);
		@(posedge clk_i);
	endtask
	task automatic t_reset();
		rchk(`ICU_IDX_ENA_LOW, 32'hFFFF);
		rchk(`ICU_IDX_ENA_HIGH, 32'hFFFF);
		rchk(`ICU_IDX_TRAP_CTRL, 32'h0);
		rchk(`ICU_IDX_NMI_STAT, 32'h0);
		rchk(`ICU_IDX_VECTOR, 32'h10);
		rchk(4'h3, 32'h0);
		chk(last_err, 1);
	endtask
	task automatic t_levels();
		xfer(1'b1, `ICU_IDX_ENA_LOW, 32'h0);
		xfer(1'b1, `ICU_IDX_ENA_HIGH, 32'h0);
		irq <= {1'b1, 29'h0, 1'b1};
		repeat (5) @(posedge clk_i);
		rchk(`ICU_IDX_LEVEL_LOW, 32'h2);
		rchk(`ICU_IDX_LEVEL_HIGH, 32'h8000);
		chk(irq_o, 0);
		xfer(1'b1, `ICU_IDX_ENA_HIGH, 32'h8000);
		core_vec(8'h2F);
	endtask
	task automatic t_prio();
		xfer(1'b1, `ICU_IDX_ENA_LOW, 32'hFFFF);
		xfer(1'b1, `ICU_IDX_ENA_HIGH, 32'hFFFF);
		for (int n = 1; n < 32; n++) begin
			irq <= 31'h1 << (n - 1);
			hold <= n[3:0];
			core_vec(8'h10 + n[7:0]);
		end
		irq <= '1;
		xfer(1'b1, `ICU_IDX_ENA_HIGH, 32'h7FFF);
		core_vec(8'h2E);
	endtask
	task automatic t_nmi();
		xfer(1'b1, `ICU_IDX_TRAP_CTRL, 32'h1);
		pin_fall();
		rchk(`ICU_IDX_TRAP_CTRL, 32'h2);
		xfer(1'b1, `ICU_IDX_TRAP_CTRL, 32'h3);
		rchk(`ICU_IDX_TRAP_CTRL, 32'h2);
		rchk(`ICU_IDX_NMI_STAT, 32'h1);
		rchk(`ICU_IDX_NMI_STAT, 32'h0);
		nmi <= 1'b1;
		xfer(1'b1, `ICU_IDX_TRAP_CTRL, 32'h5);
		rchk(`ICU_IDX_TRAP_CTRL, 32'h5);
		xfer(1'b1, `ICU_IDX_TRAP_CTRL, 32'h0);
		rchk(`ICU_IDX_TRAP_CTRL, 32'h4);
		pin_fall();
		nmi <= 1'b1;
		repeat (4) @(posedge clk_i);
		pin_fall();
	endtask
	// ----------------------------------------
	// Clock, timeout and sequence
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	initial begin
		{rst_i, cyc, we, adr, dat, irq, nmi, hold} = {3'b100, 4'h0, 32'h0, 31'h0, 1'b1, 4'h0};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_levels();
		t_prio();
		t_nmi();
		complete_run();
	end
endmodule
